// ### pkg/mtw_pkg.sv
// package for the multiply and table-write execution datapath
`default_nettype none
package mtw_pkg;
  // ==========================================================
  // widths and field positions
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned PROD_W    = 16;
  localparam int unsigned PTR_W     = 22;
  localparam int unsigned HOLD_N    = 8;
  localparam int unsigned HOLD_SEL_W = 3;
  localparam int unsigned BYTE_SEL_BIT = 0;
  // ==========================================================
  // reset values
  localparam logic [PROD_W-1:0] PROD_RST = 16'h0000;
  localparam logic [PTR_W-1:0]  PTR_RST  = 22'h00_0000;
  localparam logic [DATA_W-1:0] HOLD_RST = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
  // ==========================================================
  // pointer update codes carried in the two low opcode bits
  typedef enum logic [1:0] {
    MTW_UPD_NONE     = 2'h0,
    MTW_UPD_POST_INC = 2'h1,
    MTW_UPD_POST_DEC = 2'h2,
    MTW_UPD_PRE_INC  = 2'h3
  } mtw_upd_t;
  // ==========================================================
  // cycle counts
  localparam int unsigned MUL_CYCLES = 1;
  localparam int unsigned TABLE_WRITE_OP_CYCLES = 2;
endpackage : mtw_pkg
`default_nettype wire

// ### tb/mtw_checker.sv
// assertion checker for the multiply and table-write datapath
`default_nettype none
module mtw_checker (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_b,
  // issue and operands
  input wire logic        multiply_literal_op,
  input wire logic        multiply_register_op,
  input wire logic        table_write_op,
  input wire logic        access_sel,
  input wire logic [1:0]  pointer_update_field,
  input wire logic [7:0]  literal_k,
  input wire logic [7:0]  file_addr,
  input wire logic [7:0]  wreg,
  input wire logic [7:0]  file_data,
  input wire logic [7:0]  table_latch,
  // results
  input wire logic        file_rd_banked,
  input wire logic        busy,
  input wire logic        done,
  input wire logic [7:0]  file_rd_addr,
  input wire logic [7:0]  product_high,
  input wire logic [7:0]  product_low,
  input wire logic [7:0]  word_lsb_q,
  input wire logic [7:0]  word_msb_q,
  input wire logic [21:0] table_pointer,
  input wire logic [63:0] hold_regs
);
  // a table write is taken only while idle; refused ones must not count
  wire logic        tw_go  = table_write_op & ~busy;
  wire logic [21:0] ptr_nx = pointer_update_field == 2'h2 ? table_pointer - 22'h1
                             : table_pointer + 22'(pointer_update_field[0]);
  wire logic [21:0] wr_at  = pointer_update_field == 2'h3 ? table_pointer + 22'h1 : table_pointer;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ======================================
  // properties
  a_lit_product: assert property (
    multiply_literal_op |=> {product_high, product_low} == $past(wreg) * $past(literal_k)) else $error("lit product");
  a_reg_product: assert property (
    multiply_register_op & ~multiply_literal_op |=> {product_high, product_low} == $past(wreg) * $past(file_data))
    else $error("reg product");
  a_bank_select: assert property (
    multiply_register_op |=> file_rd_banked == $past(access_sel) && file_rd_addr == $past(file_addr))
    else $error("file request");
  a_prod_hold: assert property (
    !(multiply_literal_op | multiply_register_op) |=> $stable({product_high, product_low})) else $error("prod moved");
  a_mul_done: assert property (
    multiply_literal_op | multiply_register_op |=> done) else $error("mul done");
  a_tw_timing: assert property (
    tw_go |=> busy && !done ##1 !busy && done) else $error("tw timing");
  a_ptr_update: assert property (
    tw_go |=> table_pointer == $past(ptr_nx)) else $error("ptr update");
  a_hold_write: assert property (
    tw_go |=> ##1 hold_regs[{$past(wr_at[2:0], 2), 3'h0} +: 8] == $past(table_latch, 2)) else $error("hold write");
  a_word_byte: assert property (
    tw_go |=> ##1 ($past(wr_at[0], 2) ? word_msb_q : word_lsb_q) == $past(table_latch, 2)) else $error("word byte");
endmodule : mtw_checker
bind mtw_exec mtw_checker u_chk (
  .core_clk             (core_clk),
  .rst_b                (rst_b),
  .multiply_literal_op  (multiply_literal_op),
  .multiply_register_op (multiply_register_op),
  .table_write_op       (table_write_op),
  .access_sel           (access_sel),
  .pointer_update_field (pointer_update_field),
  .literal_k            (literal_k),
  .file_addr            (file_addr),
  .wreg                 (wreg),
  .file_data            (file_data),
  .table_latch          (table_latch),
  .file_rd_banked       (file_rd_banked),
  .busy                 (busy),
  .done                 (done),
  .file_rd_addr         (file_rd_addr),
  .product_high         (product_high),
  .product_low          (product_low),
  .word_lsb_q           (word_lsb_q),
  .word_msb_q           (word_msb_q),
  .table_pointer        (table_pointer),
  .hold_regs            (hold_regs)
);
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the multiply and table-write datapath
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import mtw_pkg::*;
  // ======================================
  // stimulus and observed signals
  logic core_clk = 0, rst_b = 0, multiply_literal_op = 0, multiply_register_op = 0;
  logic table_write_op = 0, access_sel = 0, ptr_load = 0, file_rd_banked, busy, done;
  logic [1:0]  pointer_update_field = 0;
  logic [7:0]  literal_k = 0, file_addr = 0, wreg = 0, file_data = 0, table_latch = 0;
  logic [7:0]  file_rd_addr, product_high, product_low, word_lsb_q, word_msb_q;
  logic [21:0] ptr_load_val = 0, table_pointer;
  logic [63:0] hold_regs;
  int fail_count = 0, compares = 0;
  mtw_exec DUT (
    .core_clk             (core_clk),
    .rst_b                (rst_b),
    .multiply_literal_op  (multiply_literal_op),
    .multiply_register_op (multiply_register_op),
    .table_write_op       (table_write_op),
    .literal_k            (literal_k),
    .pointer_update_field (pointer_update_field),
    .access_sel           (access_sel),
    .file_addr            (file_addr),
    .wreg                 (wreg),
    .file_data            (file_data),
    .table_latch          (table_latch),
    .ptr_load             (ptr_load),
    .ptr_load_val         (ptr_load_val),
    .file_rd_banked       (file_rd_banked),
    .file_rd_addr         (file_rd_addr),
    .product_high         (product_high),
    .product_low          (product_low),
    .table_pointer        (table_pointer),
    .hold_regs            (hold_regs),
    .word_lsb_q           (word_lsb_q),
    .word_msb_q           (word_msb_q),
    .busy                 (busy),
    .done                 (done)
  );
  // 4 ns core clock
  always #2 core_clk = ~core_clk;
  task automatic chk(input logic [63:0] got, exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  // one multiply; leaves its strobe up so the next can follow back to back
  task automatic mul(input logic rg, input logic [7:0] a, b);
    wreg = a;
    multiply_literal_op = !rg;
    multiply_register_op = rg;
    literal_k = b;
    file_data = b;
    file_addr = b;
    access_sel = b[0];
    @(negedge core_clk);
    chk({product_high, product_low}, 16'(a) * 16'(b));
    chk(done, 1);
    if (rg) chk({file_rd_banked, file_rd_addr}, {b[0], b});
  endtask : mul
  task automatic t_mul;
    mul(0, 8'hE2, 8'hC4);
    mul(0, 8'hFF, 8'hFF);
    mul(1, 8'hC4, 8'hB5);
    mul(1, 8'h00, 8'h8A);
    mul(0, 8'h01, 8'h7F);
    multiply_literal_op = 0;
    @(negedge core_clk);
    chk({product_high, product_low}, 16'h007F);
    chk(done, 0);
    $display("multiply test finished");
  endtask : t_mul
  // load pointer, table write, then a refused write and load while busy
  task automatic tw(input logic [1:0] f, input logic [21:0] p, input logic [7:0] d);
    logic [21:0] np;
    logic [21:0] wa;
    np = (f == 2'h1 || f == 2'h3) ? p + 22'h1 : (f == 2'h2 ? p - 22'h1 : p);
    wa = f == 2'h3 ? np : p;
    @(negedge core_clk);
    ptr_load = 1;
    ptr_load_val = p;
    @(negedge core_clk);
    ptr_load = 0;
    table_write_op = 1;
    pointer_update_field = f;
    table_latch = d;
    @(negedge core_clk);
    chk({busy, done, table_pointer}, {2'b10, np});
    ptr_load = 1;
    ptr_load_val = ~p;
    @(negedge core_clk);
    table_write_op = 0;
    ptr_load = 0;
    chk(hold_regs[{wa[2:0], 3'h0} +: 8], d);
    chk(wa[0] ? word_msb_q : word_lsb_q, d);
    chk({busy, done, table_pointer}, {2'b01, np});
  endtask : tw
  task automatic t_tw;
    logic [21:0] p [4] = '{22'h3F_FFFF, 22'h00_A356, 22'h00_0000, 22'h01_389A};
    for (int i = 0; i < 4; i++) tw(2'(i), p[i], 8'h30 + 8'(i));
    // writes landed in registers 7, 6, 0 and 3; others untouched
    chk(hold_regs, 64'h3031_0000_3300_0032);
    chk({word_msb_q, word_lsb_q}, 16'h3332);
    $display("table write test finished");
  endtask : t_tw
  // mid-run reset clears all results, then a multiply right after release
  task automatic t_rst;
    rst_b = 0;
    @(negedge core_clk);
    chk({product_high, product_low, busy, done, table_pointer, word_msb_q, word_lsb_q}, 0);
    chk(hold_regs, 0);
    rst_b = 1;
    mul(1, 8'h5A, 8'h03);
    multiply_register_op = 0;
    $display("reset test finished");
  endtask : t_rst
  // main sequence: reset, reset values, then scenarios
  initial begin
    repeat (16) @(negedge core_clk);
    chk({product_high, product_low, busy, done, table_pointer}, 0);
    chk(hold_regs, 0);
    rst_b = 1;
    t_mul;
    t_tw;
    t_rst;
    close_out;
  end
  // watchdog: the tests need well under a hundred cycles
  initial begin
    #8000;
    fail_count++;
    close_out;
  end
endmodule : testbench
`default_nettype wire

// ### verilog/mtw_exec.sv
// execution datapath for literal multiply, register multiply and table write
`default_nettype none
module mtw_exec (
  // clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           rst_b,
  // instruction issue from decoder
  input  wire logic                           multiply_literal_op,
  input  wire logic                           multiply_register_op,
  input  wire logic                           table_write_op,
  input  wire logic [mtw_pkg::DATA_W-1:0]     literal_k,
  input  wire logic [1:0]                     pointer_update_field,
  input  wire logic                           access_sel,
  input  wire logic [mtw_pkg::DATA_W-1:0]     file_addr,
  // register file side
  input  wire logic [mtw_pkg::DATA_W-1:0]     wreg,
  input  wire logic [mtw_pkg::DATA_W-1:0]     file_data,
  input  wire logic [mtw_pkg::DATA_W-1:0]     table_latch,
  input  wire logic                           ptr_load,
  input  wire logic [mtw_pkg::PTR_W-1:0]      ptr_load_val,
  // file register read request
  output logic                                file_rd_banked,
  output logic      [mtw_pkg::DATA_W-1:0]     file_rd_addr,
  // results
  output logic      [mtw_pkg::DATA_W-1:0]     product_high,
  output logic      [mtw_pkg::DATA_W-1:0]     product_low,
  output logic      [mtw_pkg::PTR_W-1:0]      table_pointer,
  output logic      [mtw_pkg::HOLD_N*mtw_pkg::DATA_W-1:0] hold_regs,
  output logic      [mtw_pkg::DATA_W-1:0]     word_lsb_q,
  output logic      [mtw_pkg::DATA_W-1:0]     word_msb_q,
  output logic                                busy,
  output logic                                done
);
  import mtw_pkg::*;

  logic [PROD_W-1:0]  mul_p;
  logic [DATA_W-1:0]  mul_b;
  logic [PROD_W-1:0]  prod_q;
  logic [PTR_W-1:0]   ptr_q;
  logic [PTR_W-1:0]   wr_addr;
  logic [DATA_W-1:0]  hold_q [HOLD_N];
  logic               tw_q;
  logic [PTR_W-1:0]   tw_addr_q;
  logic [DATA_W-1:0]  tw_data_q;
  logic               done_q;
  logic               rd_bank_q;
  logic [DATA_W-1:0]  rd_addr_q;
  mtw_upd_t           upd;
  logic               mul_go;
  logic               tw_go;

  // ==========================================================
  // next pointer for one update code; pre- and post-increment
  // both end one higher, they differ only in the write address
  function automatic logic [PTR_W-1:0] step_ptr(input mtw_upd_t code, input logic [PTR_W-1:0] ptr);
    unique case (code)
      MTW_UPD_NONE:     step_ptr = ptr;
      MTW_UPD_POST_INC: step_ptr = ptr + PTR_W'(1);
      MTW_UPD_POST_DEC: step_ptr = ptr - PTR_W'(1);
      MTW_UPD_PRE_INC:  step_ptr = ptr + PTR_W'(1);
    endcase
  endfunction : step_ptr

  // ==========================================================
  // issue decode shared by several processes
  // a table write is only taken while the previous one is idle
  always_comb begin
    mul_go = multiply_literal_op || multiply_register_op;
    tw_go  = table_write_op && !tw_q;
  end

  // ==========================================================
  // multiplier operand select
  // literal wins the operand if the decoder raises both strobes
  // literal operand select
  always_comb begin
    mul_b = multiply_literal_op ? literal_k : file_data;
  end

  mtw_mult u_mult (
    .a (wreg),
    .b (mul_b),
    .p (mul_p)
  );

  // ==========================================================
  // product pair; wreg and file data are only read, never written
  // no flags, accumulator untouched
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prod_q <= PROD_RST;
    end else if (mul_go) begin
      prod_q <= mul_p;
    end
  end

  // ==========================================================
  // file register address, registered for the read port
  // limitation: the request appears one cycle after issue
  // access bit picks bank
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_bank_q <= 1'b0;
      rd_addr_q <= BYTE_RST;
    end else begin
      rd_bank_q <= access_sel;
      rd_addr_q <= file_addr;
    end
  end

  // ==========================================================
  // write address: pre-increment applies before the write
  always_comb begin
    upd = mtw_upd_t'(pointer_update_field);
    wr_addr = (upd == MTW_UPD_PRE_INC) ? step_ptr(upd, ptr_q) : ptr_q;
  end

  // ==========================================================
  // table pointer update
  // pointer update modes
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_q <= PTR_RST;
    end else if (ptr_load && !tw_q) begin
      // a load in the busy cycle is dropped so the pointer keeps its stepped value
      ptr_q <= ptr_load_val;
    end else if (tw_go) begin
      ptr_q <= step_ptr(upd, ptr_q);
    end
  end

  // ==========================================================
  // two-cycle table write: capture latch, then write holding reg
  // the latch byte is captured on issue, so the decoder may move on
  // table write takes two cycles
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tw_q      <= 1'b0;
      tw_addr_q <= PTR_RST;
      tw_data_q <= BYTE_RST;
    end else if (tw_go) begin
      tw_q      <= 1'b1;
      tw_addr_q <= wr_addr;
      tw_data_q <= table_latch;
    end else begin
      tw_q      <= 1'b0;
    end
  end

  // ==========================================================
  // holding registers, one per pointer low-bit value
  // only reset clears them; they are shown flat on hold_regs
  generate
    for (genvar i = 0; i < HOLD_N; i++) begin : g_hold
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          hold_q[i] <= HOLD_RST;
        end else if (tw_q && tw_addr_q[HOLD_SEL_W-1:0] == HOLD_SEL_W'(i)) begin
          hold_q[i] <= tw_data_q;
        end
      end
    end
  endgenerate

  // ==========================================================
  // byte lane view of the last written word
  // only the newest byte per lane is kept, older ones live in hold_regs
  // pointer bit zero selects byte
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      word_lsb_q <= BYTE_RST;
      word_msb_q <= BYTE_RST;
    end else if (tw_q) begin
      if (tw_addr_q[BYTE_SEL_BIT]) begin
        word_msb_q <= tw_data_q;
      end else begin
        word_lsb_q <= tw_data_q;
      end
    end
  end

  // ==========================================================
  // completion pulse: multiply same edge, table write second edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      done_q <= 1'b0;
    end else begin
      // done marks the cycle in which the results are valid
      done_q <= mul_go || tw_q;
    end
  end

  // ==========================================================
  // outputs straight from flip-flops
  always_comb begin
    product_high   = prod_q[PROD_W-1:DATA_W];
    product_low    = prod_q[DATA_W-1:0];
    table_pointer  = ptr_q;
    busy           = tw_q;
    done           = done_q;
    file_rd_banked = rd_bank_q;
    file_rd_addr   = rd_addr_q;
    // flat view, holding register j in byte lane j
    for (int j = 0; j < HOLD_N; j++) begin
      hold_regs[j*DATA_W +: DATA_W] = hold_q[j];
    end
  end
endmodule : mtw_exec
`default_nettype wire

// ### verilog/mtw_mult.sv
// unsigned 8x8 multiplier core, combinational
`default_nettype none
module mtw_mult (
  // operands
  input  wire logic [mtw_pkg::DATA_W-1:0] a,
  input  wire logic [mtw_pkg::DATA_W-1:0] b,
  // product
  output logic      [mtw_pkg::PROD_W-1:0] p
);
  import mtw_pkg::*;
  // ==========================================================
  // product always fits in sixteen bits, nothing to flag
  always_comb begin
    p = PROD_W'(a) * PROD_W'(b);
  end
endmodule : mtw_mult
`default_nettype wire
